// ===== hw/bmmc_pkg.sv
// Purpose: shared types and constants for the boot mode and module control block
// Assumes: one 50 MHz clock, asynchronous active-low reset
// Notes: boot mode encodings and timer pulse length live here
package bmmc_pkg;
  typedef enum logic [2:0] {
    BMMC_BOOT_EPROM,
    BMMC_BOOT_HOST,
    BMMC_BOOT_LINK,
    BMMC_BOOT_NONE,
    BMMC_BOOT_RESERVED
  } bmmc_boot_mode_t;

  typedef struct packed {
    logic eprom_boot_select;
    logic link_boot_select;
    logic boot_memory_select;
  } bmmc_straps_t;

  localparam int unsigned BMMC_NUM_PROC = 4;
  localparam int unsigned BMMC_TIMEXP_CYCLES = 4;
  localparam logic [2:0] BMMC_TIMEXP_LOAD = 3'h4;
  localparam int unsigned BMMC_TIMER_COUNT_VALUE_W = 32;
  localparam int unsigned BMMC_ID_W = 3;
  localparam int unsigned BMMC_SYNC_W = 3;
endpackage

// ===== hw/bmmc_top.sv
// Purpose: boot mode selection, boot chip select, timer-expired pulses and test chain
// Assumes: strap pins are static, test pins are slow against the system clock
// Notes: test chain is a bypass model, one flop per processor
`timescale 1ns/1ps
`default_nettype none
module bmmc_top
  import bmmc_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic arst_n,
  // Boot straps
  input wire bmmc_straps_t straps,
  input wire logic bus_master,
  input wire logic boot_cs_request,
  // Boot memory select pin
  output logic boot_mem_chip_select_o,
  output logic boot_mem_chip_select_oe,
  // Boot mode status
  output bmmc_boot_mode_t boot_mode,
  output logic eprom_boot_cfg,
  output logic link_boot_cfg,
  output logic boot_8bit_eprom,
  // Timers
  input wire logic [BMMC_NUM_PROC-1:0] timer_enable,
  input wire logic [BMMC_NUM_PROC-1:0] timer_count_zero,
  output logic [BMMC_NUM_PROC-1:0] timer_expired_out,
  // Shared flag and ids
  input wire logic [BMMC_NUM_PROC-1:0] shared_flag_drive,
  output logic shared_flag_line,
  output logic [BMMC_NUM_PROC*BMMC_ID_W-1:0] proc_id,
  // Test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic test_reset_state
);

  // ==========================================================
  // Input synchronisers
  // Straps and test pins come from outside; two flops before use.
  logic [BMMC_SYNC_W-1:0] strap_s1_reg, strap_s2_reg;
  logic [3:0] tst_s1_reg, tst_s2_reg, tst_prev_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1_reg <= '0;
      strap_s2_reg <= '0;
      tst_s1_reg <= 4'h0;
      tst_s2_reg <= 4'h0;
      tst_prev_reg <= 4'h0;
    end else begin
      strap_s1_reg <= straps;
      strap_s2_reg <= strap_s1_reg;
      tst_s1_reg <= {trst_n, tdi, tms, tck};
      tst_s2_reg <= tst_s1_reg;
      tst_prev_reg <= tst_s2_reg;
    end
  end

  // ==========================================================
  // Boot mode decode and capture
  bmmc_straps_t strap_sync;
  assign strap_sync = bmmc_straps_t'(strap_s2_reg);
  bmmc_boot_mode_t mode_next, mode_reg;
  logic captured_reg;
  wire e_sel = strap_sync.eprom_boot_select;
  wire l_sel = strap_sync.link_boot_select;
  wire b_sel = strap_sync.boot_memory_select;
  // Reserved strap combinations fall to the reserved code; system must avoid them.
  assign mode_next = (e_sel && !l_sel) ? BMMC_BOOT_EPROM :
                     (e_sel) ? BMMC_BOOT_RESERVED :
                     (!l_sel && !b_sel) ? BMMC_BOOT_NONE :
                     (!l_sel && b_sel) ? BMMC_BOOT_HOST :
                     (l_sel && b_sel) ? BMMC_BOOT_LINK :
                     BMMC_BOOT_RESERVED;

  // Capture a few cycles after release so the synchroniser has filled.
  logic [1:0] settle_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      settle_reg <= 2'h0;
      captured_reg <= 1'b0;
      mode_reg <= BMMC_BOOT_NONE;
    end else begin
      if (settle_reg != 2'h3) settle_reg <= settle_reg + 2'h1;
      if (settle_reg == 2'h3 && !captured_reg) begin
        captured_reg <= 1'b1;
        mode_reg <= mode_next;
      end
    end
  end
  assign boot_mode = mode_reg;
  assign eprom_boot_cfg = captured_reg && (mode_reg == BMMC_BOOT_EPROM);
  assign link_boot_cfg = captured_reg && (mode_reg == BMMC_BOOT_LINK);
  assign boot_8bit_eprom = eprom_boot_cfg;

  // ==========================================================
  // Boot chip select pin (active low, driven only by bus master in EPROM mode)
  // Registered so the pin never glitches while the request decodes
  logic cs_o_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) cs_o_reg <= 1'b1;
    else cs_o_reg <= !(boot_cs_request && eprom_boot_cfg);
  end
  assign boot_mem_chip_select_oe = eprom_boot_cfg && bus_master;
  assign boot_mem_chip_select_o = cs_o_reg;

  // ==========================================================
  // Timer expired pulses, one counter per processor
  genvar g;
  generate
    for (g = 0; g < BMMC_NUM_PROC; g++) begin : g_tmr
      logic [2:0] tx_cnt_reg;
      wire fire = timer_enable[g] && timer_count_zero[g];
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) tx_cnt_reg <= 3'h0;
        else if (fire) tx_cnt_reg <= BMMC_TIMEXP_LOAD;
        else if (tx_cnt_reg != 3'h0) tx_cnt_reg <= tx_cnt_reg - 3'h1;
      end
      assign timer_expired_out[g] = (tx_cnt_reg != 3'h0);
      // A new expiry reloads the count, so a retrigger only stretches the pulse
      a_timexp_len: assert property (@(posedge clock) disable iff (!arst_n)
        fire |=> timer_expired_out[g] [*4])
        else $error("timer pulse too short");
      a_timexp_end: assert property (@(posedge clock) disable iff (!arst_n)
        fire ##1 (!fire) [*4] |=> !timer_expired_out[g])
        else $error("timer pulse too long");
      assign proc_id[g*BMMC_ID_W +: BMMC_ID_W] = BMMC_ID_W'(g + 1);
    end
  endgenerate
  // Open-drain style wired-low shared line
  assign shared_flag_line = ~|shared_flag_drive;

  // ==========================================================
  // Test chain: sampled test clock edges, four bypass stages A to D
  // Idle-low reset value: no false test clock edge right after reset
  wire tck_rise = tst_s2_reg[0] && !tst_prev_reg[0];
  wire tms_s = tst_s2_reg[1];
  wire tdi_s = tst_s2_reg[2];
  wire trst_s_n = tst_s2_reg[3];
  logic [BMMC_NUM_PROC-1:0] chain_reg;
  logic [2:0] tms_ones_reg;
  logic tdo_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      chain_reg <= '0;
      tms_ones_reg <= 3'h0;
      tdo_reg <= 1'b0;
    end else if (!trst_s_n) begin
      tms_ones_reg <= 3'h0;
      chain_reg <= '0;
    end else if (tck_rise) begin
      // Five consecutive TMS highs reach test-logic-reset
      if (!tms_s) tms_ones_reg <= 3'h0;
      else if (tms_ones_reg != 3'h5) tms_ones_reg <= tms_ones_reg + 3'h1;
      chain_reg <= {chain_reg[BMMC_NUM_PROC-2:0], tdi_s};
      tdo_reg <= chain_reg[BMMC_NUM_PROC-1];
    end
  end
  assign tdo = tdo_reg;
  assign test_reset_state = !trst_s_n || (tms_ones_reg == 3'h5);

  // ==========================================================
  // Checks
  // Pin drive follows the captured mode, never the live straps
  a_eprom_drive: assert property (@(posedge clock) disable iff (!arst_n)
    boot_mem_chip_select_oe |-> (mode_reg == BMMC_BOOT_EPROM && bus_master))
    else $error("chip select driven outside EPROM mode");
  a_master_only: assert property (@(posedge clock) disable iff (!arst_n)
    !bus_master |-> !boot_mem_chip_select_oe)
    else $error("non master drives chip select");
  a_no_boot: assert property (@(posedge clock) disable iff (!arst_n)
    (settle_reg == 2'h3 && !captured_reg && !e_sel && !l_sel && !b_sel) |=> mode_reg == BMMC_BOOT_NONE)
    else $error("no-boot not selected");
  a_host_boot: assert property (@(posedge clock) disable iff (!arst_n)
    (settle_reg == 2'h3 && !captured_reg && !e_sel && !l_sel && b_sel) |=> mode_reg == BMMC_BOOT_HOST)
    else $error("host boot not selected");
  a_link_boot: assert property (@(posedge clock) disable iff (!arst_n)
    (settle_reg == 2'h3 && !captured_reg && !e_sel && l_sel && b_sel) |=> link_boot_cfg)
    else $error("link boot not selected");
  a_mode_hold: assert property (@(posedge clock) disable iff (!arst_n)
    captured_reg |=> $stable(mode_reg))
    else $error("boot mode changed after capture");
  a_trst_reset: assert property (@(posedge clock) disable iff (!arst_n)
    !trst_s_n |=> (tms_ones_reg == 3'h0 && chain_reg == '0))
    else $error("test reset ignored");
  a_float_eprom: assert property (@(posedge clock) disable iff (!arst_n)
    (mode_reg != BMMC_BOOT_EPROM) |-> !boot_mem_chip_select_oe)
    else $error("pin output outside EPROM mode");
  a_cs_assert: assert property (@(posedge clock) disable iff (!arst_n)
    (boot_cs_request && eprom_boot_cfg) |=> !boot_mem_chip_select_o)
    else $error("chip select not asserted on request");
  c_eprom: cover property (@(posedge clock) disable iff (!arst_n) boot_mem_chip_select_oe && !boot_mem_chip_select_o);
  c_link: cover property (@(posedge clock) disable iff (!arst_n) link_boot_cfg);
  c_timexp: cover property (@(posedge clock) disable iff (!arst_n) $rose(timer_expired_out[3]));
  c_tlr: cover property (@(posedge clock) disable iff (!arst_n) trst_s_n && tms_ones_reg == 3'h5);
  c_no_boot: cover property (@(posedge clock) disable iff (!arst_n) captured_reg && mode_reg == BMMC_BOOT_NONE);

endmodule // bmmc_top
`default_nettype wire

// ===== verification/bmmc_pin_model.sv
// Purpose: boot pin and boot EPROM model
// Assumes: strap level is hardwired by the bench
// Notes: counts cycles with chip select driven low (oe high and cs_o low)
`timescale 1ns/1ps
`default_nettype none
module bmmc_pin_model (
  // System
  input wire logic clock,
  // Boot pin
  input wire logic cs_o,
  input wire logic oe,
  input wire logic strap_level,
  output logic pin_level,
  output logic [7:0] cs_count
);
  // ==========
  // Pin level
  // Strap wiring only wins while the device is not driving
  assign pin_level = oe ? cs_o : strap_level;
  initial cs_count = 8'h00;
  always @(posedge clock) begin
    if (oe && !cs_o) cs_count <= cs_count + 8'h01;
  end
endmodule // bmmc_pin_model
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: self-checking bench for boot mode and module control
// Assumes: 50 MHz clock, straps fixed within each reset but the last, which changes them after capture
// Notes: tck runs slow against the system clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bmmc_pkg::*;
  // ==========
  // Signals
  logic clock = 1'b0, arst_n = 1'b0, bus_master = 1'b1, boot_cs_request = 1'b0;
  logic e_sel = 1'b0, l_sel = 1'b0, strap_level = 1'b1, pin_level, ep;
  logic tck = 1'b0, tms = 1'b1, tdi = 1'b0, trst_n = 1'b0;
  logic [3:0] timer_enable = 4'h0, timer_count_zero = 4'h0, shared_flag_drive = 4'h0, timer_expired_out;
  logic boot_mem_chip_select_o, boot_mem_chip_select_oe, eprom_boot_cfg, link_boot_cfg, boot_8bit_eprom;
  logic shared_flag_line, tdo, test_reset_state;
  logic [11:0] proc_id;
  logic [7:0] cs_count;
  bmmc_straps_t straps;
  bmmc_boot_mode_t boot_mode, exp;
  int mismatches = 0, checks = 0, cycles = 0, n0, n2, n3, first;
  assign straps = {e_sel, l_sel, pin_level};
  always #10 clock = ~clock;
  bmmc_top DUT (.clock, .arst_n, .straps, .bus_master, .boot_cs_request, .boot_mem_chip_select_o,
    .boot_mem_chip_select_oe, .boot_mode, .eprom_boot_cfg, .link_boot_cfg, .boot_8bit_eprom, .timer_enable,
    .timer_count_zero, .timer_expired_out, .shared_flag_drive, .shared_flag_line, .proc_id, .tck, .tms, .tdi,
    .trst_n, .tdo, .test_reset_state);
  bmmc_pin_model eprom (.clock, .cs_o(boot_mem_chip_select_o), .oe(boot_mem_chip_select_oe),
    .strap_level, .pin_level, .cs_count);
  // ==========
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check_val(input string name, input logic [11:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic check_mode(input bmmc_boot_mode_t e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value boot_mode expected %0d seen %0d", e, g);
    end
  endtask
  task automatic do_reset(input logic e, l, s);
    @(posedge clock) begin arst_n <= 1'b0; e_sel <= e; l_sel <= l; strap_level <= s; end
    tick(12);
    @(posedge clock) arst_n <= 1'b1;
    tick(8);
  endtask
  task automatic tck_bit(input logic d, m);
    @(posedge clock) begin tdi <= d; tms <= m; end
    tick(4);
    @(posedge clock) tck <= 1'b1;
    tick(6);
    @(posedge clock) tck <= 1'b0;
    tick(6);
  endtask
  function automatic bmmc_boot_mode_t exp_mode(input logic [2:0] s);
    if (s[2]) return s[1] ? BMMC_BOOT_RESERVED : BMMC_BOOT_EPROM;
    case (s[1:0])
      2'b00: return BMMC_BOOT_NONE;
      2'b01: return BMMC_BOOT_HOST;
      2'b11: return BMMC_BOOT_LINK;
      default: return BMMC_BOOT_RESERVED;
    endcase
  endfunction
  // ==========
  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // ==========
  // Tests
  initial begin
    for (int i = 0; i < 8; i++) begin
      do_reset(i[2], i[1], i[0]);
      exp = exp_mode(i[2:0]);
      ep = (i[2:1] == 2'b10);
      check_mode(exp, boot_mode);
      check_val("eprom_boot_cfg", 12'(ep), 12'(eprom_boot_cfg));
      check_val("boot_8bit_eprom", 12'(ep), 12'(boot_8bit_eprom));
      check_val("link_boot_cfg", 12'(exp == BMMC_BOOT_LINK), 12'(link_boot_cfg));
      check_val("oe", 12'(ep), 12'(boot_mem_chip_select_oe));
      @(posedge clock) boot_cs_request <= 1'b1;
      tick(2);
      check_val("cs_o", 12'(!ep), 12'(boot_mem_chip_select_o));
      @(posedge clock) begin boot_cs_request <= 1'b0; bus_master <= 1'b0; end
      tick(1);
      check_val("oe_slave", 12'h000, 12'(boot_mem_chip_select_oe));
      @(posedge clock) bus_master <= 1'b1;
    end
    check_val("cs_count", 12'h004, 12'(cs_count));
    do_reset(1'b0, 1'b0, 1'b1);
    @(posedge clock) begin e_sel <= 1'b1; strap_level <= 1'b0; end
    tick(8);
    check_mode(BMMC_BOOT_HOST, boot_mode);
    @(posedge clock) begin timer_enable <= 4'hC; timer_count_zero <= 4'hD; end
    @(posedge clock) timer_count_zero <= 4'h0;
    n0 = 0;
    n2 = 0;
    n3 = 0;
    tick(0);
    repeat (10) begin
      n0 += timer_expired_out[0];
      n2 += timer_expired_out[2];
      n3 += timer_expired_out[3];
      tick(1);
    end
    check_val("timer_a", 12'h000, 12'(n0));
    check_val("timer_c", 12'h004, 12'(n2));
    check_val("timer_d", 12'h004, 12'(n3));
    @(posedge clock) shared_flag_drive <= 4'h8;
    tick(1);
    check_val("flag", 12'h000, 12'(shared_flag_line));
    @(posedge clock) shared_flag_drive <= 4'h0;
    tick(1);
    check_val("flag", 12'h001, 12'(shared_flag_line));
    check_val("proc_id", 12'h8D1, proc_id);
    check_val("test_reset_state", 12'h001, 12'(test_reset_state));
    @(posedge clock) trst_n <= 1'b1;
    tck_bit(1'b0, 1'b0);
    tck_bit(1'b0, 1'b0);
    check_val("test_reset_state", 12'h000, 12'(test_reset_state));
    repeat (5) tck_bit(1'b0, 1'b1);
    check_val("test_reset_state", 12'h001, 12'(test_reset_state));
    first = 0;
    for (int k = 1; k < 9; k++) begin
      tck_bit(k == 1, 1'b0);
      if (tdo === 1'b1 && first == 0) first = k;
    end
    check_val("tdo_delay", 12'h005, 12'(first));
    test_done();
  end
endmodule // testbench
`default_nettype wire
